// File: hw/tx_irq_pkg.sv
// constants and types for the transmitter interrupt configuration block
package tx_irq_pkg;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] TX_STATUS_OFFSET    = 8'h0a;
   localparam logic [7:0] TX_IRQ_MASK_OFFSET  = 8'h0b;
   localparam logic [7:0] TX_IRQ_MODE_OFFSET  = 8'h0c;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int XFER_DONE_MASK_BIT   = 0;
   localparam int SLIP_MASK_BIT        = 1;
   localparam int XFER_DONE_MODE_LSB   = 0;
   localparam int SLIP_MODE_LSB        = 2;
   localparam int XFER_DONE_FLAG_BIT   = 0;
   localparam int SLIP_FLAG_BIT        = 1;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [1:0] TX_IRQ_MASK_RESET  = 2'h0;
   localparam logic [3:0] TX_IRQ_MODE_RESET  = 4'h0;
   localparam logic [7:0] TX_RDATA_RESET     = 8'h00;

   // event indices
   localparam int EVT_XFER_DONE = 0;
   localparam int EVT_SLIP      = 1;
   localparam int EVT_COUNT     = 2;

   typedef enum logic [1:0] {
      TRIG_RISE  = 2'b00,
      TRIG_FALL  = 2'b01,
      TRIG_LEVEL = 2'b10,
      TRIG_RSVD  = 2'b11
   } trig_mode_e;

endpackage : tx_irq_pkg

// File: hw/event_trigger_cell.sv
// one interrupt event: edge or level detection, mask and a flag that is sticky in the two edge modes
`timescale 1ns/1ps
module event_trigger_cell
   import tx_irq_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       cond,
   input  wire logic [1:0] mode,
   input  wire logic       mask,
   input  wire logic       clear,
   output logic            flag
);

   typedef struct packed {
      logic prev;
      logic flag;
   } cell_s;

   cell_s state;
   cell_s next_state;

   always_comb begin
      next_state      = state;
      next_state.prev = cond;
      // ------------------------------------------------------------
      // trigger decode
      // ------------------------------------------------------------
      case (trig_mode_e'(mode))
         TRIG_RISE: begin
            if (clear)
               next_state.flag = 1'b0;
            if (mask && cond && !state.prev)
               next_state.flag = 1'b1;
         end
         TRIG_FALL: begin
            if (clear)
               next_state.flag = 1'b0;
            if (mask && !cond && state.prev)
               next_state.flag = 1'b1;
         end
         TRIG_LEVEL: begin
            next_state.flag = mask && cond;
         end
         default: begin
            // reserved code never raises the event
            next_state.flag = 1'b0;
         end
      endcase
      // masked events never raise the flag
      if (!mask)
         next_state.flag = 1'b0;
   end

   always_ff @(posedge clk) begin
      if (rst)
         state <= '0;
      else if (ce)
         state <= next_state;
   end

   assign flag = state.flag;

endmodule : event_trigger_cell

// File: hw/transmitter_interrupt_config.sv
// transmitter interrupt mask, trigger mode and interrupt pin logic
//
// Behaviour
// - The mask register holds the slip mask in bit 1 and the transfer mask in bit 0, upper bits read zero.
// - A transfer mask of 0, the reset value, suppresses the transfer interrupt and 1 allows it.
// - A slip mask of 0, the reset value, suppresses the slip interrupt and 1 allows it.
// - The mode register holds the slip trigger mode in bits 3:2 and the transfer mode in bits 1:0, upper bits zero.
// - Transfer mode 00 is rising edge (default), 01 falling edge, 10 level, 11 reserved.
// - Slip mode 00 is rising edge (default), 01 falling edge, 10 level, 11 reserved.
// - With transfers enabled and unmasked, a completed transfer sets its flag, pulls the pin low and sets the summary.
// - With slip unmasked, a slip or block start, chosen by a select bit, sets its flag, pulls the pin low and sets the summary.
`timescale 1ns/1ps
module transmitter_interrupt_config
   import tx_irq_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic [7:0]      reg_rdata,
   input  wire logic       xfer_done,
   input  wire logic       tx_transfer_disable,
   input  wire logic       data_slip,
   input  wire logic       block_start,
   input  wire logic       slip_source_select,
   output logic            xfer_done_flag,
   output logic            slip_flag,
   output logic            tx_summary,
   output logic            int_n
);

   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offset);
      addr_hit = (addr == offset);
   endfunction : addr_hit

   typedef struct packed {
      logic       slip_irq_mask;
      logic       xfer_done_irq_mask;
      logic [1:0] slip_trigger_mode;
      logic [1:0] xfer_done_trigger_mode;
      logic [7:0] rdata;
      logic       xfer_q;
      logic       slip_q;
      logic       summary;
      logic       int_n;
   } ctrl_s;

   ctrl_s state;
   ctrl_s next_state;

   logic [EVT_COUNT-1:0] ev_cond;
   logic [EVT_COUNT-1:0] ev_mask;
   logic [1:0]           ev_mode [EVT_COUNT];
   logic [EVT_COUNT-1:0] ev_flag;
   logic                 status_clear;

   // ------------------------------------------------------------
   // event sources
   // ------------------------------------------------------------
   assign ev_cond[EVT_XFER_DONE] = xfer_done && !tx_transfer_disable;
   assign ev_cond[EVT_SLIP]      = slip_source_select ? block_start : data_slip;
   assign ev_mask[EVT_XFER_DONE] = state.xfer_done_irq_mask;
   assign ev_mask[EVT_SLIP]      = state.slip_irq_mask;
   assign ev_mode[EVT_XFER_DONE] = state.xfer_done_trigger_mode;
   assign ev_mode[EVT_SLIP]      = state.slip_trigger_mode;

   // status read clears the edge flags; a new event in that cycle still sets
   assign status_clear = reg_rd && addr_hit(reg_addr, TX_STATUS_OFFSET);

   // ------------------------------------------------------------
   // per event trigger cells
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < EVT_COUNT; gi++) begin : g_evt
         event_trigger_cell u_cell (
            .clk   (clk),
            .rst   (rst),
            .ce    (ce),
            .cond  (ev_cond[gi]),
            .mode  (ev_mode[gi]),
            .mask  (ev_mask[gi]),
            .clear (status_clear),
            .flag  (ev_flag[gi])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // register file and pin
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      if (reg_wr) begin
         if (addr_hit(reg_addr, TX_IRQ_MASK_OFFSET)) begin
            next_state.xfer_done_irq_mask = reg_wdata[XFER_DONE_MASK_BIT];
            next_state.slip_irq_mask      = reg_wdata[SLIP_MASK_BIT];
         end else if (addr_hit(reg_addr, TX_IRQ_MODE_OFFSET)) begin
            next_state.xfer_done_trigger_mode = reg_wdata[XFER_DONE_MODE_LSB +: 2];
            next_state.slip_trigger_mode      = reg_wdata[SLIP_MODE_LSB +: 2];
         end
      end
      if (reg_rd) begin
         next_state.rdata = TX_RDATA_RESET;
         if (addr_hit(reg_addr, TX_STATUS_OFFSET)) begin
            next_state.rdata[XFER_DONE_FLAG_BIT] = ev_flag[EVT_XFER_DONE];
            next_state.rdata[SLIP_FLAG_BIT]      = ev_flag[EVT_SLIP];
         end else if (addr_hit(reg_addr, TX_IRQ_MASK_OFFSET)) begin
            next_state.rdata[XFER_DONE_MASK_BIT] = state.xfer_done_irq_mask;
            next_state.rdata[SLIP_MASK_BIT]      = state.slip_irq_mask;
         end else if (addr_hit(reg_addr, TX_IRQ_MODE_OFFSET)) begin
            next_state.rdata[XFER_DONE_MODE_LSB +: 2] = state.xfer_done_trigger_mode;
            next_state.rdata[SLIP_MODE_LSB +: 2]      = state.slip_trigger_mode;
         end
      end
      next_state.xfer_q  = ev_flag[EVT_XFER_DONE];
      next_state.slip_q  = ev_flag[EVT_SLIP];
      next_state.summary = |ev_flag;
      next_state.int_n   = !(|ev_flag);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state.xfer_done_irq_mask     <= TX_IRQ_MASK_RESET[XFER_DONE_MASK_BIT];
         state.slip_irq_mask          <= TX_IRQ_MASK_RESET[SLIP_MASK_BIT];
         state.xfer_done_trigger_mode <= TX_IRQ_MODE_RESET[XFER_DONE_MODE_LSB +: 2];
         state.slip_trigger_mode      <= TX_IRQ_MODE_RESET[SLIP_MODE_LSB +: 2];
         state.rdata                  <= TX_RDATA_RESET;
         state.xfer_q                 <= 1'b0;
         state.slip_q                 <= 1'b0;
         state.summary                <= 1'b0;
         state.int_n                  <= 1'b1;
      end else if (ce) begin
         state <= next_state;
      end
   end

   assign reg_rdata      = state.rdata;
   assign xfer_done_flag = state.xfer_q;
   assign slip_flag      = state.slip_q;
   assign tx_summary     = state.summary;
   assign int_n          = state.int_n;

endmodule : transmitter_interrupt_config

// File: test/tx_irq_sva.sv
// port assertions for the transmitter interrupt configuration block
`timescale 1ns/1ps
module tx_irq_sva
   import tx_irq_pkg::*;
(
   input logic       clk,
   input logic       rst,
   input logic       ce,
   input logic       reg_wr,
   input logic       reg_rd,
   input logic [7:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic [7:0] reg_rdata,
   input logic       xfer_done,
   input logic       tx_transfer_disable,
   input logic       xfer_done_flag,
   input logic       slip_flag,
   input logic       tx_summary,
   input logic       int_n
);
   logic [1:0] xm;
   logic [3:0] xmode;
   logic       rise_x;
   logic       lvl_x;
   // shadow copies of the mask and mode registers
   always_ff @(posedge clk) begin
      if (rst) begin
         xm    <= 2'h0;
         xmode <= 4'h0;
      end else if (ce && reg_wr && reg_addr == TX_IRQ_MASK_OFFSET) begin
         xm <= reg_wdata[1:0];
      end else if (ce && reg_wr && reg_addr == TX_IRQ_MODE_OFFSET) begin
         xmode <= reg_wdata[3:0];
      end
   end
   assign rise_x = ce && xm[0] && xmode[1:0] == 2'b00 && !tx_transfer_disable;
   assign lvl_x  = ce && xm[0] && xmode[1:0] == 2'b10 && !tx_transfer_disable;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   AST_RESET_STATE: assert property (disable iff (1'b0) rst |=> int_n && !tx_summary && reg_rdata == 8'h00)
      else $error("outputs not at reset values");
   AST_PIN_SUMMARY: assert property (!int_n == tx_summary && tx_summary == (xfer_done_flag | slip_flag))
      else $error("pin and summary disagree with flags");
   AST_MASK_FIELDS: assert property (ce && reg_rd && reg_addr == TX_IRQ_MASK_OFFSET |=> reg_rdata == {6'h00, $past(xm)})
      else $error("mask read value wrong");
   AST_MODE_FIELDS: assert property (ce && reg_rd && reg_addr == TX_IRQ_MODE_OFFSET |=> reg_rdata == {4'h0, $past(xmode)})
      else $error("mode read value wrong");
   AST_XFER_GATED: assert property (!xm[0] && !$past(xm[0]) && !$past(xm[0], 2) |-> !xfer_done_flag)
      else $error("masked transfer flag set");
   AST_SLIP_GATED: assert property (!xm[1] && !$past(xm[1]) && !$past(xm[1], 2) |-> !slip_flag)
      else $error("masked slip flag set");
   AST_LEVEL_FOLLOW: assert property (lvl_x && $past(lvl_x) && $past(lvl_x, 2) |-> xfer_done_flag == $past(xfer_done, 2))
      else $error("level flag does not follow condition");
   AST_RISE_SETS: assert property (rise_x && $past(rise_x) && $past(rise_x, 2) && $past(rise_x, 3)
      && $past(xfer_done, 2) && !$past(xfer_done, 3) |-> xfer_done_flag)
      else $error("rising edge missed");
   cover property ($rose(xfer_done_flag));
   cover property ($rose(slip_flag));
   cover property (ce && reg_rd && reg_addr == TX_STATUS_OFFSET && tx_summary);
endmodule : tx_irq_sva

// File: test/host_irq_model.sv
// host model: counts interrupt pin assertions
`timescale 1ns/1ps
module host_irq_model (
   input  logic       clk,
   input  logic       rst,
   input  logic       int_n,
   output logic [7:0] irq_seen
);
   logic last_n;
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_seen <= 8'h00;
         last_n   <= 1'b1;
      end else begin
         last_n <= int_n;
         if (last_n && !int_n) irq_seen <= irq_seen + 8'h01;
      end
   end
endmodule : host_irq_model

// File: test/testbench.sv
// self-checking bench for the transmitter interrupt configuration block
`timescale 1ns/1ps
module testbench;
   import tx_irq_pkg::*;
   logic       clk = 0, rst = 1, ce = 1, reg_wr = 0, reg_rd = 0, tx_transfer_disable = 0, slip_source_select = 0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, irq_seen;
   logic [2:0] evs = 3'b000;
   logic       xfer_done_flag, slip_flag, tx_summary, int_n;
   int         n_fail = 0, n_compared = 0;
   always #20 clk = ~clk;
   transmitter_interrupt_config transmitter_interrupt_config_i (.clk, .rst, .ce, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata, .xfer_done(evs[0]), .tx_transfer_disable, .data_slip(evs[1]),
      .block_start(evs[2]), .slip_source_select, .xfer_done_flag, .slip_flag, .tx_summary, .int_n);
   host_irq_model host_irq_model_i (.clk, .rst, .int_n, .irq_seen);
   task conclude;
      if (n_fail == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : conclude
   task chk(input logic [7:0] s, input logic [7:0] e);
      n_compared++;
      if (s !== e) begin
         n_fail++;
         $display("FAIL %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask : cyc
   task wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1;
      cyc(1);
      reg_wr = 0;
      cyc(1);
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr = a;
      reg_rd = 1;
      cyc(1);
      reg_rd = 0;
      cyc(1);
      chk(reg_rdata, e);
   endtask : rd
   // raise then drop one event source, check flag, pin and status read
   task trig(input int k, input logic [1:0] m, input logic h, input logic l);
      slip_source_select = (k == 2);
      wr(TX_IRQ_MODE_OFFSET, k == 0 ? {6'h00, m} : {4'h0, m, 2'b00});
      evs[k] = 1'b1;
      cyc(3);
      chk(k == 0 ? xfer_done_flag : slip_flag, h);
      chk({tx_summary, int_n}, {h, !h});
      evs[k] = 1'b0;
      cyc(3);
      chk(k == 0 ? xfer_done_flag : slip_flag, l);
      rd(TX_STATUS_OFFSET, k == 0 ? {7'h00, l} : {6'h00, l, 1'b0});
      chk(int_n, 1'b1);
   endtask : trig
   initial begin
      cyc(4);
      rst = 0;
      cyc(1);
      rd(TX_IRQ_MASK_OFFSET, 8'h00);
      rd(TX_IRQ_MODE_OFFSET, 8'h00);
      trig(0, 2'b00, 0, 0);
      trig(1, 2'b00, 0, 0);
      wr(TX_IRQ_MASK_OFFSET, 8'hff);
      rd(TX_IRQ_MASK_OFFSET, 8'h03);
      wr(TX_IRQ_MODE_OFFSET, 8'hff);
      rd(TX_IRQ_MODE_OFFSET, 8'h0f);
      rd(8'h0d, 8'h00);
      for (int k = 0; k < 3; k++) begin
         for (int m = 0; m < 4; m++) begin
            trig(k, 2'(m), m == 0 || m == 2, m < 2);
         end
      end
      tx_transfer_disable = 1;
      trig(0, 2'b00, 0, 0);
      chk(irq_seen, 8'h09);
      // clock enable low freezes edge detection; block start chosen, data slip ignored
      tx_transfer_disable = 0;
      slip_source_select = 1;
      ce = 0;
      evs[1:0] = 2'b11;
      cyc(3);
      chk({xfer_done_flag, slip_flag, int_n}, 3'b001);
      ce = 1;
      cyc(3);
      chk({xfer_done_flag, slip_flag}, 2'b10);
      rd(TX_STATUS_OFFSET, 8'h01);
      evs[1:0] = 2'b00;
      conclude;
   end
   initial begin
      #100000;
      n_fail++;
      conclude;
   end
endmodule : testbench
bind transmitter_interrupt_config tx_irq_sva tx_irq_sva_i (.clk, .rst, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
   .reg_rdata, .xfer_done, .tx_transfer_disable, .xfer_done_flag, .slip_flag, .tx_summary, .int_n);
